// ### bfsc_pkg.sv
// Constants for the buck fault supervisor and start-up configuration block.
// Assumes a 200 MHz core clock; analog comparators arrive as digital flags.
// Function
// R1 - Bias lockout: off below low, on above high
// R2 - Output undervoltage tri-states every phase output
// R3 - Undervoltage waits hiccup delay, restarts, repeats
// R4 - Tracking overvoltage: ready low, phases forced low
// R5 - During target change use fixed overvoltage level
// R6 - Fixed overvoltage latched until enable/bias cycle
// R7 - Pre-bias overvoltage latched until bias cycle
// R8 - Valley limit withholds phase on-pulse
// R9 - Monitor overcurrent above limit: hiccup until clear
// R10 - Over-temperature off, restart 15 degrees lower
// R11 - Warning temperature drives warning pin low
// R12 - Warning setting only bus-written, never stored
// R13 - Severe fault pin low on listed faults
// R14 - Tied sense input sets phase count 1-4
// R15 - Config source pin selects straps or memory
// R16 - Bus address always from address strap
// R17 - Config latched at 3.3 V rail power-up
// R18 - Frequency: strap 3-bit in 6:4, memory 4-bit
// R19 - Boot code: seven strap bits plus address LSB
// R20 - Regulate to boot code until command changes
// R21 - Mode strap decodes into four mode selections
// R22 - Mode bits 7, 6, 4, 3 as listed
// R23 - Address strap: 4-bit address, rise rate, LSB
// R24 - Flags synchronous; hiccup delay counted in cycles
// R25 - Soft clear leaves overvoltage latches alone
`default_nettype none
package bfsc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;            // Core clock rate
  localparam int HICCUP_MS = 22;           // Hiccup delay
  localparam int HICCUP_CYC = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int HICCUP_W = 23;            // Hiccup counter width
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTRL = 4'h0;    // W bit0: soft clear
  localparam logic [3:0] A_STATUS = 4'h1;  // Fault and state view
  localparam logic [3:0] A_VOUT = 4'h2;    // Output voltage command
  localparam logic [3:0] A_BOOT = 4'h3;    // Boot code
  localparam logic [3:0] A_MODE = 4'h4;    // Mode bits
  localparam logic [3:0] A_FREQ = 4'h5;    // Frequency config field
  localparam logic [3:0] A_OCLIM = 4'h6;   // Overcurrent fault limit
  localparam logic [3:0] A_OTTHR = 4'h7;   // Over-temperature threshold
  localparam logic [3:0] A_WARN = 4'h8;    // Warning temperature
  localparam logic [3:0] A_PHADDR = 4'h9;  // Phase count, bus address
  localparam logic [3:0] A_RISE = 4'hA;    // Soft-start rise rate
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_DAC = 7;             // DAC mode select
  localparam int MODE_PAIR = 6;            // Paired interleaving
  localparam int MODE_SHED = 4;            // Dynamic phase add/drop
  localparam int MODE_ZLL = 3;             // Zero load-line
  localparam int FREQ_LSB = 4;             // Frequency code position
  localparam logic [7:0] OT_THR_RST = 8'h7D;   // 125 degrees
  localparam logic [7:0] WARN_RST = 8'h6E;     // 110 degrees
  localparam logic [8:0] OT_HYST = 9'h00F;     // 15 degrees
  localparam logic [2:0] PH_MAX = 3'h4;        // Phases when none tied
  // ----------------------------------------------------------------
  // Per-phase output codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PWM_RUN = 2'h0;   // Normal switching
  localparam logic [1:0] PWM_TRI = 2'h1;   // Both switches off
  localparam logic [1:0] PWM_LOW = 2'h2;   // Low side on
  localparam logic [1:0] PWM_HOLD = 2'h3;  // Next on-pulse withheld
  // Supervisor states
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_HICCUP, ST_OTP} bfsc_st_t;
endpackage
`default_nettype wire

// ### bfsc_top.sv
// Fault supervisor and start-up configuration for a 4-phase buck control.
// Assumes all flag and code inputs are synchronous to CORE_CLK_I.
`timescale 1ns/1ps
`default_nettype none
module bfsc_top #(
  parameter int HICCUP_CYCLES = bfsc_pkg::HICCUP_CYC,  // Hiccup delay
  parameter int PHASES = 4                             // Phase outputs
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RD_DATA_O,
  // Supply and enable flags
  input wire logic BIAS_LOW_I,
  input wire logic BIAS_HIGH_I,
  input wire logic INPUT_SUPPLY_OK_I,
  input wire logic ENABLE_I,
  // Output voltage comparator flags
  input wire logic TRACK_UV_I,
  input wire logic TRACK_OV_M0_I,
  input wire logic TRACK_OV_M1_I,
  input wire logic FIXED_OV_M0_I,
  input wire logic FIXED_OV_M1_I,
  input wire logic DAC_CHANGING_I,
  input wire logic PREBIAS_OV_I,
  // Current and temperature
  input wire logic [3:0] VALLEY_OVER_I,
  input wire logic [7:0] CURRENT_MONITOR_I,
  input wire logic INPUT_OC_I,
  input wire logic [7:0] TEMPERATURE_I,
  input wire logic STAGE_FAULT_I,
  // Start-up configuration
  input wire logic AUX_3V3_UP_I,
  input wire logic PHASE_TWO_TIED_I,
  input wire logic PHASE_THREE_TIED_I,
  input wire logic PHASE_FOUR_TIED_I,
  input wire logic CONFIG_SOURCE_STRAP_I,
  input wire logic [6:0] BOOT_STRAP_I,
  input wire logic [3:0] ADDR_VOLT_CODE_I,
  input wire logic [2:0] ADDR_RES_CODE_I,
  input wire logic [3:0] MODE_STRAP_I,
  input wire logic [2:0] FREQ_STRAP_I,
  input wire logic [7:0] IMAX_CODE_I,
  input wire logic [7:0] NVM_BOOT_I,
  input wire logic [7:0] NVM_MODE_I,
  input wire logic [3:0] NVM_FREQ_I,
  input wire logic [1:0] NVM_RISE_I,
  // Outputs
  output logic [7:0] PWM_STATE_O,
  output logic REGULATOR_READY_O,
  output logic THERMAL_WARNING_N_O,
  output logic SEVERE_FAULT_N_O,
  output logic [7:0] TARGET_CODE_O,
  output logic [3:0] PMBUS_ADDR_O,
  output logic [2:0] PHASE_COUNT_O,
  output logic [7:0] MODE_BITS_O,
  output logic [7:0] FREQ_FIELD_O,
  output logic [1:0] RISE_RATE_O
);
  import bfsc_pkg::*;

  // Elaboration check on parameters
  if (HICCUP_CYCLES < 2 || HICCUP_CYCLES >= (1 << HICCUP_W) || PHASES != 4)
  begin : g_bad_param
    $error("bfsc_top: unsupported parameter value");
  end

  localparam logic [HICCUP_W-1:0] HIC_LAST = HICCUP_W'(HICCUP_CYCLES - 1);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  bfsc_st_t state;                  // Supervisor state
  logic bias_ok;                    // Bias above lockout
  logic ov_latch;                   // Fixed overvoltage latch
  logic pb_latch;                   // Pre-bias overvoltage latch
  logic [HICCUP_W-1:0] hic_cnt;     // Hiccup delay counter
  logic aux_q;                      // Rail level last cycle
  logic soft_clr;                   // Soft clear pulse
  logic [7:0] oc_limit;             // Overcurrent fault limit
  logic [7:0] ot_thr;               // Over-temperature threshold
  logic [7:0] warn_temp;            // Warning temperature
  logic [7:0] boot_code;            // Latched boot code

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic run_ok, cfg_load, wr_hit, track_hit, fixed_hit, ov_now;
  logic oc_hit, ot_hit, ot_cool;
  assign run_ok = bias_ok && INPUT_SUPPLY_OK_I && ENABLE_I;  // [R1]
  assign cfg_load = AUX_3V3_UP_I && !aux_q;                  // [R17]
  assign wr_hit = WR_I && !RD_I;
  // Tracking compare blanked while target moves  [R4] [R5]
  assign track_hit = !DAC_CHANGING_I &&
    (MODE_BITS_O[MODE_DAC] ? TRACK_OV_M1_I : TRACK_OV_M0_I);
  assign fixed_hit = DAC_CHANGING_I &&
    (MODE_BITS_O[MODE_DAC] ? FIXED_OV_M1_I : FIXED_OV_M0_I);  // [R5]
  assign ov_now = track_hit || fixed_hit || ov_latch || pb_latch;
  assign oc_hit = CURRENT_MONITOR_I > oc_limit;               // [R9]
  assign ot_hit = TEMPERATURE_I > ot_thr;                     // [R10]
  assign ot_cool = ({1'b0, TEMPERATURE_I} + OT_HYST) <= {1'b0, ot_thr};

  // Strap mode code to mode field  [R21] [R22]
  function automatic logic [7:0] mode_field(input logic [3:0] c);
    logic [7:0] m;
    m = 8'h00;
    m[MODE_DAC] = c[3];
    m[MODE_PAIR] = c[2];
    m[MODE_SHED] = c[1];
    m[MODE_ZLL] = c[0];
    return m;
  endfunction

  // Saturating 1.25 times maximum current  [R9]
  function automatic logic [7:0] oc_default(input logic [7:0] imax);
    logic [9:0] s;
    s = {2'b00, imax} + {4'h0, imax[7:2]};
    return (s > 10'h0FF) ? 8'hFF : s[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Bias lockout with hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bias_ok <= 1'b0;
    end else if (BIAS_LOW_I) begin
      bias_ok <= 1'b0;  // [R1]
    end else if (BIAS_HIGH_I) begin
      bias_ok <= 1'b1;  // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Overvoltage latches
  // ----------------------------------------------------------------
  // Fixed latch: set wins, cleared by enable or bias cycle
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ov_latch <= 1'b0;
    end else if (fixed_hit) begin
      ov_latch <= 1'b1;  // [R6]
    end else if (!ENABLE_I || !bias_ok) begin
      ov_latch <= 1'b0;  // [R6] [R25]
    end
  end

  // Pre-bias latch: only a bias cycle clears it
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pb_latch <= 1'b0;
    end else if (!ENABLE_I && PREBIAS_OV_I) begin
      pb_latch <= 1'b1;  // [R7]
    end else if (!bias_ok) begin
      pb_latch <= 1'b0;  // [R7] [R25]
    end
  end

  // ----------------------------------------------------------------
  // Supervisor state machine and hiccup counter
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_OFF;
      hic_cnt <= '0;
    end else if (!run_ok || soft_clr) begin
      state <= ST_OFF;  // [R1] [R25]
      hic_cnt <= '0;
    end else begin
      case (state)
        ST_OFF: begin
          state <= ST_RUN;
        end
        ST_RUN: begin
          hic_cnt <= '0;
          if (ot_hit) begin
            state <= ST_OTP;  // [R10]
          end else if (oc_hit || TRACK_UV_I) begin
            state <= ST_HICCUP;  // [R2] [R9]
          end
        end
        ST_HICCUP: begin
          if (hic_cnt != HIC_LAST) begin
            hic_cnt <= hic_cnt + 1'b1;  // [R24]
          end else if (oc_hit) begin
            hic_cnt <= '0;  // Stay off while overcurrent persists [R9]
          end else begin
            state <= ST_RUN;  // Restart, may fault again [R3]
          end
        end
        ST_OTP: begin
          if (ot_cool) begin
            state <= ST_RUN;  // [R10]
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-phase output control
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PHASES; gi++) begin : g_phase
      always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          PWM_STATE_O[2*gi +: 2] <= PWM_TRI;
        end else if (ov_now) begin
          PWM_STATE_O[2*gi +: 2] <= PWM_LOW;  // [R4] [R6] [R7]
        end else if (state != ST_RUN || STAGE_FAULT_I ||
                     3'(gi) >= PHASE_COUNT_O) begin
          PWM_STATE_O[2*gi +: 2] <= PWM_TRI;  // [R2] [R9] [R10]
        end else if (VALLEY_OVER_I[gi]) begin
          PWM_STATE_O[2*gi +: 2] <= PWM_HOLD;  // [R8]
        end else begin
          PWM_STATE_O[2*gi +: 2] <= PWM_RUN;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Indication pins
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REGULATOR_READY_O <= 1'b0;
      THERMAL_WARNING_N_O <= 1'b1;
      SEVERE_FAULT_N_O <= 1'b1;
    end else begin
      REGULATOR_READY_O <= !ov_now && state == ST_RUN;       // [R4] [R6]
      THERMAL_WARNING_N_O <= !(TEMPERATURE_I > warn_temp);    // [R11]
      SEVERE_FAULT_N_O <= !(INPUT_OC_I || ot_hit || state == ST_OTP ||
                            ov_now || STAGE_FAULT_I);         // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Start-up configuration latch
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aux_q <= 1'b0;
    end else begin
      aux_q <= AUX_3V3_UP_I;
    end
  end

  // Address and phase count always come from pins
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PMBUS_ADDR_O <= 4'h0;
      PHASE_COUNT_O <= PH_MAX;
    end else if (cfg_load) begin
      PMBUS_ADDR_O <= ADDR_VOLT_CODE_I;  // [R16] [R23]
      if (PHASE_TWO_TIED_I) begin
        PHASE_COUNT_O <= 3'h1;  // [R14]
      end else if (PHASE_THREE_TIED_I) begin
        PHASE_COUNT_O <= 3'h2;
      end else if (PHASE_FOUR_TIED_I) begin
        PHASE_COUNT_O <= 3'h3;
      end else begin
        PHASE_COUNT_O <= PH_MAX;
      end
    end
  end

  // Selectable values: latched at power-up, rewritable afterwards
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      boot_code <= 8'h00;
      MODE_BITS_O <= 8'h00;
      FREQ_FIELD_O <= 8'h00;
      RISE_RATE_O <= 2'h0;
      oc_limit <= 8'hFF;
    end else if (cfg_load) begin
      oc_limit <= oc_default(IMAX_CODE_I);
      if (CONFIG_SOURCE_STRAP_I) begin  // [R15]
        boot_code <= {BOOT_STRAP_I, ADDR_RES_CODE_I[0]};  // [R19] [R23]
        MODE_BITS_O <= mode_field(MODE_STRAP_I);          // [R21]
        FREQ_FIELD_O <= {1'b0, FREQ_STRAP_I, 4'h0};       // [R18]
        RISE_RATE_O <= ADDR_RES_CODE_I[2:1];              // [R23]
      end else begin
        boot_code <= NVM_BOOT_I;
        MODE_BITS_O <= NVM_MODE_I;
        FREQ_FIELD_O <= {NVM_FREQ_I, 4'h0};               // [R18]
        RISE_RATE_O <= NVM_RISE_I;
      end
    end else if (wr_hit) begin
      case (ADDR_I)
        A_BOOT: boot_code <= WR_DATA_I;                   // [R17]
        A_MODE: MODE_BITS_O <= WR_DATA_I;
        A_FREQ: FREQ_FIELD_O <= WR_DATA_I;
        A_RISE: RISE_RATE_O <= WR_DATA_I[1:0];
        A_OCLIM: oc_limit <= WR_DATA_I;
        default: begin
        end
      endcase
    end
  end

  // Thresholds set only through the register port
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ot_thr <= OT_THR_RST;
      warn_temp <= WARN_RST;
    end else if (wr_hit && ADDR_I == A_OTTHR) begin
      ot_thr <= WR_DATA_I;
    end else if (wr_hit && ADDR_I == A_WARN) begin
      warn_temp <= WR_DATA_I;  // [R12]
    end
  end

  // Regulation target: boot code at start, then command  [R20]
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TARGET_CODE_O <= 8'h00;
    end else if (state != ST_RUN) begin
      TARGET_CODE_O <= boot_code;  // [R3] [R10] [R20]
    end else if (wr_hit && ADDR_I == A_VOUT) begin
      TARGET_CODE_O <= WR_DATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Register port: soft clear and read data
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      soft_clr <= 1'b0;
    end else begin
      soft_clr <= wr_hit && ADDR_I == A_CTRL && WR_DATA_I[0];  // [R25]
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RD_DATA_O <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        A_STATUS: RD_DATA_O <= {ov_latch, pb_latch, oc_hit, ot_hit,
                                bias_ok, run_ok, state};
        A_VOUT: RD_DATA_O <= TARGET_CODE_O;
        A_BOOT: RD_DATA_O <= boot_code;
        A_MODE: RD_DATA_O <= MODE_BITS_O;
        A_FREQ: RD_DATA_O <= FREQ_FIELD_O;
        A_OCLIM: RD_DATA_O <= oc_limit;
        A_OTTHR: RD_DATA_O <= ot_thr;
        A_WARN: RD_DATA_O <= warn_temp;
        A_PHADDR: RD_DATA_O <= {1'b0, PHASE_COUNT_O, PMBUS_ADDR_O};
        A_RISE: RD_DATA_O <= {6'h00, RISE_RATE_O};
        default: RD_DATA_O <= 8'h00;
      endcase
    end else begin
      RD_DATA_O <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  chk_bias_lockout: assert property ( // [R1]
    BIAS_LOW_I |-> ##2 (state == ST_OFF) ##1 (PWM_STATE_O[1:0] != PWM_RUN))
    else $error("bias lockout did not stop switching");
  chk_uv_tristate: assert property ( // [R2]
    (state == ST_RUN && run_ok && !soft_clr && TRACK_UV_I && !ot_hit)
    |=> state == ST_HICCUP ##1 (ov_now || PWM_STATE_O[1:0] == PWM_TRI))
    else $error("undervoltage did not tri-state the phases");
  chk_hiccup_wait: assert property ( // [R3]
    (state == ST_HICCUP && run_ok && !soft_clr && hic_cnt != HIC_LAST)
    |=> state == ST_HICCUP && hic_cnt == $past(hic_cnt) + 1'b1)
    else $error("hiccup ended before its delay");
  chk_ov_drive_low: assert property ( // [R4]
    ov_now |=> PWM_STATE_O == {4{PWM_LOW}} && !REGULATOR_READY_O)
    else $error("overvoltage did not force outputs low");
  chk_track_blank: assert property ( // [R5]
    (DAC_CHANGING_I && !ov_latch && !pb_latch && !FIXED_OV_M0_I &&
     !FIXED_OV_M1_I) |-> !ov_now)
    else $error("tracking overvoltage not blanked");
  chk_fixed_hold: assert property ( // [R6]
    (ov_latch && ENABLE_I && bias_ok) |=> ov_latch)
    else $error("fixed overvoltage latch dropped");
  chk_prebias_hold: assert property ( // [R7]
    (!ENABLE_I && PREBIAS_OV_I) |=> pb_latch ##0 (bias_ok || pb_latch)
    ##1 (!$past(bias_ok) || pb_latch))
    else $error("pre-bias latch did not hold");
  chk_valley_hold: assert property ( // [R8]
    (state == ST_RUN && !ov_now && !STAGE_FAULT_I && VALLEY_OVER_I[0])
    |=> PWM_STATE_O[1:0] == PWM_HOLD)
    else $error("valley limit did not withhold on-pulse");
  chk_otp_enter: assert property ( // [R10]
    (state == ST_RUN && run_ok && !soft_clr && ot_hit) |=> state == ST_OTP)
    else $error("over-temperature did not stop regulation");
  chk_warn_pin: assert property ( // [R11]
    (TEMPERATURE_I > warn_temp) |=> !THERMAL_WARNING_N_O)
    else $error("warning pin not low above setting");
  chk_severe_pin: assert property ( // [R13]
    (INPUT_OC_I || STAGE_FAULT_I) |=> !SEVERE_FAULT_N_O)
    else $error("severe fault pin not low");
  chk_addr_strap: assert property ( // [R16]
    cfg_load |=> PMBUS_ADDR_O == $past(ADDR_VOLT_CODE_I))
    else $error("address not taken from strap");

  cov_hiccup_restart: cover property (
    state == ST_HICCUP ##1 state == ST_RUN);
  cov_otp_recover: cover property (state == ST_OTP ##1 state == ST_RUN);
  cov_fixed_ov: cover property ($rose(ov_latch));
  cov_nvm_load: cover property (cfg_load && !CONFIG_SOURCE_STRAP_I);
endmodule
`default_nettype wire

// ### bfsc_far_model.sv
// Far-side model: output stage and load under a commanded sag.
// Assumes PWM codes from bfsc_pkg and one core clock.
`timescale 1ns/1ps
`default_nettype none
module bfsc_far_model (
  input wire logic clk_i,
  input wire logic [7:0] pwm_state_i,
  input wire logic sag_i,
  output logic track_uv_o
);
  import bfsc_pkg::*;
  // ----------------------------------------------------------------
  // Output comparator
  // ----------------------------------------------------------------
  // Output collapses only while phase 0 switches under the sag load
  always_ff @(posedge clk_i) begin
    track_uv_o <= sag_i && (pwm_state_i[1:0] == PWM_RUN);
  end
endmodule
`default_nettype wire

// ### buck_fault_supervisor_config_tb_top.sv
// Self-checking bench for the fault supervisor and start-up config block.
// Assumes bfsc_pkg, bfsc_top and bfsc_far_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module buck_fault_supervisor_config_tb_top;
  import bfsc_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, rd_q = 0, bl = 0, bh = 0;
  logic en = 1, sag = 0, uv, ovt = 0, ovf = 0, dch = 0, aux = 0;
  logic [1:0] m1 = 0;
  logic [3:0] addr = 0, pa;
  logic [7:0] wd = 0, tmp = 8'h19, current_monitor = 0, nvm = 0, rdd, pwm, tgt, mb, fq;
  logic hot_n, flt_n, rdy;
  logic [2:0] pc;
  logic [1:0] rr;
  logic vin_ok = 1, pbov = 0, ioc = 0, sflt = 0, cfs = 1;
  logic [2:0] tie = 3'h4;
  logic [3:0] vov = 0;
  logic [7:0] imax = 8'h40;
  logic [7:0] exp_q[$];
  int n_errors = 0, compares = 0, seed = 36198, cycles = 0;
  // ----------------------------------------------------------------
  // Clock, random inputs, timeout
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    current_monitor <= 8'($random(seed)) & 8'h3F;
    m1 <= 2'($random(seed));
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  bfsc_far_model i_bfsc_far_model (.clk_i(clk), .pwm_state_i(pwm),
    .sag_i(sag), .track_uv_o(uv));
  bfsc_top #(.HICCUP_CYCLES(20)) i_bfsc_top (.CORE_CLK_I(clk),
    .RST_B_I(rst_b), .ADDR_I(addr), .WR_DATA_I(wd), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdd), .BIAS_LOW_I(bl), .BIAS_HIGH_I(bh),
    .INPUT_SUPPLY_OK_I(vin_ok), .ENABLE_I(en), .TRACK_UV_I(uv),
    .TRACK_OV_M0_I(ovt), .TRACK_OV_M1_I(m1[0]), .FIXED_OV_M0_I(ovf),
    .FIXED_OV_M1_I(m1[1]), .DAC_CHANGING_I(dch), .PREBIAS_OV_I(pbov),
    .VALLEY_OVER_I(vov), .CURRENT_MONITOR_I(current_monitor), .INPUT_OC_I(ioc),
    .TEMPERATURE_I(tmp), .STAGE_FAULT_I(sflt), .AUX_3V3_UP_I(aux),
    .PHASE_TWO_TIED_I(tie[0]), .PHASE_THREE_TIED_I(tie[1]),
    .PHASE_FOUR_TIED_I(tie[2]), .CONFIG_SOURCE_STRAP_I(cfs),
    .BOOT_STRAP_I(7'h2B), .ADDR_VOLT_CODE_I(4'h9), .ADDR_RES_CODE_I(3'h5),
    .MODE_STRAP_I(4'h6), .FREQ_STRAP_I(3'h5), .IMAX_CODE_I(imax),
    .NVM_BOOT_I(nvm), .NVM_MODE_I(~nvm), .NVM_FREQ_I(nvm[3:0]),
    .NVM_RISE_I(nvm[5:4]), .PWM_STATE_O(pwm), .REGULATOR_READY_O(rdy),
    .THERMAL_WARNING_N_O(hot_n), .SEVERE_FAULT_N_O(flt_n),
    .TARGET_CODE_O(tgt), .PMBUS_ADDR_O(pa), .PHASE_COUNT_O(pc),
    .MODE_BITS_O(mb), .FREQ_FIELD_O(fq), .RISE_RATE_O(rr));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Read data watcher: oldest note against the answer cycle
  always @(posedge clk) begin
    if (rd_q)
      chk(rdd, exp_q.pop_front());
    rd_q <= rd;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    chk(pwm, 8'h55);
    repeat (5) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    bh <= 1;
    aux <= 1;
    cyc(4);
    chk(tgt, 8'h57);
    chk({4'h0, pa}, 8'h09);
    chk({6'h0, rr}, 8'h02);
    chk(mb, 8'h50);
    chk(fq, 8'h50);
    chk({5'h0, pc}, 8'h03);
    chk(pwm, 8'h40);
    rd_reg(A_WARN, WARN_RST);
    rd_reg(A_OTTHR, OT_THR_RST);
    rd_reg(A_OCLIM, 8'h50);
    rd_reg(A_PHADDR, 8'h39);
    rd_reg(4'hF, 8'h00);
    wr_reg(A_WARN, 8'h50);
    rd_reg(A_WARN, 8'h50);
    wr_reg(A_VOUT, 8'h33);
    cyc(2);
    chk(tgt, 8'h33);
    @(posedge clk);
    tmp <= 8'h51;
    cyc(3);
    chk({7'h0, hot_n}, 8'h00);
    @(posedge clk);
    tmp <= 8'h50;
    cyc(3);
    chk({7'h0, hot_n}, 8'h01);
    @(posedge clk);
    sag <= 1;
    cyc(4);
    chk(pwm, 8'h55);
    @(posedge clk);
    sag <= 0;
    cyc(30);
    chk(pwm, 8'h40);
    chk(tgt, 8'h57);
    @(posedge clk);
    ovt <= 1;
    cyc(3);
    chk(pwm, 8'hAA);
    chk({7'h0, rdy}, 8'h00);
    @(posedge clk);
    dch <= 1;
    cyc(3);
    chk(pwm, 8'h40);
    @(posedge clk);
    ovf <= 1;
    @(posedge clk);
    ovf <= 0;
    ovt <= 0;
    dch <= 0;
    cyc(4);
    chk(pwm, 8'hAA);
    chk({7'h0, flt_n}, 8'h00);
    @(posedge clk);
    en <= 0;
    cyc(3);
    @(posedge clk);
    en <= 1;
    cyc(5);
    chk(pwm, 8'h40);
    // Pre-bias latch survives an enable cycle
    @(posedge clk);
    en <= 0;
    pbov <= 1;
    cyc(3);
    chk(pwm, 8'hAA);
    @(posedge clk);
    en <= 1;
    pbov <= 0;
    cyc(5);
    chk(pwm, 8'hAA);
    @(posedge clk);
    bl <= 1;
    bh <= 0;
    cyc(3);
    @(posedge clk);
    bl <= 0;
    cyc(4);
    chk(pwm, 8'h55);
    @(posedge clk);
    bh <= 1;
    cyc(4);
    chk(pwm, 8'h40);
    @(posedge clk);
    vov <= 4'h1;
    cyc(3);
    chk(pwm, 8'h43);
    @(posedge clk);
    vov <= 4'h0;
    vin_ok <= 0;
    cyc(3);
    chk(pwm, 8'h55);
    @(posedge clk);
    vin_ok <= 1;
    ioc <= 1;
    cyc(4);
    chk(pwm, 8'h40);
    chk({7'h0, flt_n}, 8'h00);
    @(posedge clk);
    ioc <= 0;
    sflt <= 1;
    cyc(3);
    chk(pwm, 8'h55);
    chk({7'h0, flt_n}, 8'h00);
    // Over-temperature entry and 15 degree hysteresis
    @(posedge clk);
    sflt <= 0;
    tmp <= 8'h7E;
    cyc(3);
    chk(pwm, 8'h55);
    chk({7'h0, flt_n}, 8'h00);
    @(posedge clk);
    tmp <= 8'h6F;
    cyc(3);
    chk(pwm, 8'h55);
    @(posedge clk);
    tmp <= 8'h6E;
    cyc(4);
    chk(pwm, 8'h40);
    chk({7'h0, flt_n}, 8'h01);
    // Second rail power-up, memory as source
    @(posedge clk);
    aux <= 0;
    cyc(2);
    @(posedge clk);
    aux <= 1;
    cfs <= 0;
    tie <= 3'h2;
    imax <= 8'hF0;
    nvm <= 8'($random(seed)) | 8'h80;
    cyc(3);
    chk(mb, ~nvm);
    chk(fq, {nvm[3:0], 4'h0});
    chk({6'h0, rr}, {6'h0, nvm[5:4]});
    chk({5'h0, pc}, 8'h02);
    chk({4'h0, pa}, 8'h09);
    chk(pwm, 8'h50);
    rd_reg(A_BOOT, nvm);
    rd_reg(A_OCLIM, 8'hFF);
    cyc(3);
    end_of_test();
  end
endmodule
`default_nettype wire
